// >>> hw/irqeb_pkg.sv
package irqeb_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [15:0] IRQEB_PEND_A_ADDR = 16'h0030; // first request bank
  localparam logic [15:0] IRQEB_PEND_B_ADDR = 16'h0031; // second request bank
  localparam logic [15:0] IRQEB_PEND_C_ADDR = 16'h0032; // third request bank
  localparam logic [15:0] IRQEB_PEND_D_ADDR = 16'h0033; // fourth request bank
  localparam logic [15:0] IRQEB_PEND_E_ADDR = 16'h0034; // fifth request bank
  localparam logic [15:0] IRQEB_ENAB_A_ADDR = 16'h0038; // first enable bank
  localparam logic [15:0] IRQEB_ENAB_B_ADDR = 16'h0039; // second enable bank
  localparam logic [15:0] IRQEB_ENAB_C_ADDR = 16'h003a; // third enable bank
  localparam logic [15:0] IRQEB_ENAB_D_ADDR = 16'h003b; // fourth enable bank

  // ----------------------------------------------------------------
  // implemented-bit masks, one per bank
  // ----------------------------------------------------------------
  localparam logic [7:0] IRQEB_MASK_A = 8'hc3; // bits 0,1,6,7
  localparam logic [7:0] IRQEB_MASK_B = 8'h7f; // bits 0..6
  localparam logic [7:0] IRQEB_MASK_C = 8'hcf; // bits 0..3,6,7
  localparam logic [7:0] IRQEB_MASK_D = 8'hbf; // all but bit 6
  localparam logic [7:0] IRQEB_MASK_E = 8'h1f; // bits 0..4

  // ----------------------------------------------------------------
  // reset values and fixed bits
  // ----------------------------------------------------------------
  localparam logic [7:0] IRQEB_RST_ZERO = 8'h00; // common reset value
  localparam logic [7:0] IRQEB_RST_E = 8'he0; // fifth bank reset value
  localparam logic [7:0] IRQEB_FIXED_E = 8'he0; // fifth bank read-as-one bits

  // ----------------------------------------------------------------
  // source numbering: vector order, lowest index served first
  // ----------------------------------------------------------------
  localparam int IRQEB_NSRC = 29; // number of sources
  localparam logic [4:0] IRQEB_NO_SRC = 5'h1f; // code when nothing pending and enabled

  // arbiter states
  typedef enum logic [2:0] {
    IRQEB_IDLE = 3'b001, // nothing offered
    IRQEB_OFFER = 3'b010, // source offered to core
    IRQEB_ACK = 3'b100 // accepted, flag already cleared
  } irqeb_state_t;

endpackage

// >>> hw/irqeb_flag_if.sv
`timescale 1ns/10ps
`default_nettype none
// flags and enables shared between bank and arbiter
interface irqeb_flag_if;
  logic [28:0] pending; // flat request flags
  logic [28:0] enable; // flat enable bits
  logic [4:0] src_id; // offered source
  logic src_valid; // a source is offered
  logic ack; // core took offered source
  modport bank (output pending, output enable, input src_id, input src_valid, output ack);
  modport arb (input pending, input enable, output src_id, output src_valid, input ack);
endinterface
`default_nettype wire

// >>> hw/irqeb_arbiter.sv
`timescale 1ns/10ps
`default_nettype none
module irqeb_arbiter
  import irqeb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  irqeb_flag_if.arb fl
);

  // ----------------------------------------------------------------
  // combinational pick of lowest vector
  // ----------------------------------------------------------------
  logic [28:0] live; // flag and enable both set
  logic [4:0] pick_nxt; // lowest live index
  logic any_nxt; // something live
  irqeb_state_t state_r; // arbiter phase
  logic [4:0] src_r; // registered choice
  logic vld_r; // registered valid

  // R22 flag and enable
  assign live = fl.pending & fl.enable;

  // R21 lowest vector first
  always_comb
  begin
    pick_nxt = IRQEB_NO_SRC;
    any_nxt = 1'b0;
    for (int i = IRQEB_NSRC - 1; i >= 0; i--)
    begin
      if (live[i])
      begin
        pick_nxt = 5'(i);
        any_nxt = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // offer register; choice held while core is accepting
  // ----------------------------------------------------------------
  // re-pick every cycle except on ack, so a late higher request still wins
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r <= IRQEB_IDLE;
      src_r <= IRQEB_NO_SRC;
      vld_r <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        IRQEB_IDLE, IRQEB_OFFER:
        begin
          if (fl.ack && vld_r)
          begin
            state_r <= IRQEB_ACK;
            vld_r <= 1'b0;
          end
          else
          begin
            state_r <= any_nxt ? IRQEB_OFFER : IRQEB_IDLE;
            src_r <= pick_nxt;
            vld_r <= any_nxt;
          end
        end
        // flag cleared on the edge into this state; re-arbitrate next
        IRQEB_ACK:
        begin
          state_r <= IRQEB_IDLE;
          src_r <= IRQEB_NO_SRC;
        end
        default:
        begin
          state_r <= IRQEB_IDLE;
          vld_r <= 1'b0;
        end
      endcase
    end
  end

  assign fl.src_id = src_r;
  assign fl.src_valid = vld_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_offer_is_live: assert property (@(posedge sys_clk) disable iff (!nrst) // R22
    vld_r |-> $past(live[pick_nxt]))
    else $error("offered source was not pending and enabled");
  a_lowest_first: assert property (@(posedge sys_clk) disable iff (!nrst) // R21
    (vld_r && !$past(fl.ack)) |-> (($past(live) & ((29'h1 << src_r) - 29'h1)) == 29'h0))
    else $error("a lower vector was pending but not offered");
  c_offer: cover property (@(posedge sys_clk) disable iff (!nrst) vld_r ##1 fl.ack);
  c_two_live: cover property (@(posedge sys_clk) disable iff (!nrst) $countones(live) > 1);
endmodule
`default_nettype wire

// >>> hw/irqeb_bank.sv
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// Function
// R1: bank a flags bits 0,1,6,7 set by source
// R2: bank b flags bits 0 to 6
// R3: bank c flags bits 0-3,6,7
// R4: bank d flags all but bit 6
// R5: bank e flags bits 0 to 4
// R6: enable a bits 0,1,6,7
// R7: enable b bits 0 to 6
// R8: enable c bits 0-3,6,7
// R9: enable d all but bit 6
// R10: bank a unused bits 2-5 read zero
// R11: bank b unused bit 7 reads zero
// R12: bank c unused bits 4,5 read zero
// R13: bank d unused bit 6 reads zero
// R14: bank e bits 5-7 ignore writes, read one
// R15: enables, banks a-d reset to zero
// R16: bank e resets to e0
// R17: software reads and writes every flag
// R18: flag one means request pending
// R19: bank b at 0031, bank d at 0033
// R20: accepted interrupt clears its flag
// R21: lowest vector offered first
// R22: offer only when flag and enable set
// R23: hardware set beats software clear
module irqeb_bank
  import irqeb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [28:0] src_event,
  input wire logic core_ack,
  output logic [4:0] irq_src_id,
  output logic irq_valid
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0] pend_a_r; // first request bank
  logic [7:0] pend_b_r; // second request bank
  logic [7:0] pend_c_r; // third request bank
  logic [7:0] pend_d_r; // fourth request bank
  logic [7:0] pend_e_r; // fifth request bank, top bits fixed
  logic [7:0] enab_a_r; // first enable bank
  logic [7:0] enab_b_r; // second enable bank
  logic [7:0] enab_c_r; // third enable bank
  logic [7:0] enab_d_r; // fourth enable bank
  logic [7:0] rdata_r; // read answer
  logic [7:0] clr_a, clr_b, clr_c, clr_d, clr_e; // ack clear per bank
  logic [7:0] set_a, set_b, set_c, set_d, set_e; // hardware set per bank

  irqeb_flag_if fl();

  // ----------------------------------------------------------------
  // source index to bank bit mapping
  // ----------------------------------------------------------------
  // vector order: a0,a1,a6,a7, b0..b6, c0..c3,c6,c7, d0..d5,d7, e0..e4
  function automatic logic [39:0] irqeb_spread(input logic [28:0] s);
    logic [39:0] o;
    o = 40'h0;
    o[1:0] = s[1:0];
    o[7:6] = s[3:2];
    o[14:8] = s[10:4];
    o[19:16] = s[14:11];
    o[23:22] = s[16:15];
    o[29:24] = s[22:17];
    o[31] = s[23];
    o[36:32] = s[28:24];
    return o;
  endfunction

  function automatic logic [28:0] irqeb_gather(input logic [39:0] b);
    logic [28:0] o;
    o = {b[36:32], b[31], b[29:24], b[23:22], b[19:16], b[14:8], b[7:6], b[1:0]};
    return o;
  endfunction

  // one-hot clear for the accepted source
  logic [39:0] ack_spread;
  // R20 clear accepted flag
  assign ack_spread = (core_ack && irq_valid) ? irqeb_spread(29'h1 << irq_src_id) : 40'h0;
  assign {clr_e, clr_d, clr_c, clr_b, clr_a} = ack_spread;

  logic [39:0] set_spread;
  assign set_spread = irqeb_spread(src_event);
  assign {set_e, set_d, set_c, set_b, set_a} = set_spread;

  // ----------------------------------------------------------------
  // flag update: write, else ack clear, then hardware set on top
  // ----------------------------------------------------------------
  // R17 software writes flag; R23 set wins last
  function automatic logic [7:0] irqeb_flag_nxt(
    input logic [7:0] cur,
    input logic wr,
    input logic [7:0] wd,
    input logic [7:0] clr,
    input logic [7:0] set,
    input logic [7:0] mask
  );
    logic [7:0] v;
    v = wr ? wd : (cur & ~clr);
    v = v | set;
    return v & mask;
  endfunction

  logic wr_pa, wr_pb, wr_pc, wr_pd, wr_pe; // request bank write hits
  logic wr_ea, wr_eb, wr_ec, wr_ed; // enable bank write hits
  // R19 fixed bank addresses
  assign wr_pa = reg_wr && (reg_addr == IRQEB_PEND_A_ADDR);
  assign wr_pb = reg_wr && (reg_addr == IRQEB_PEND_B_ADDR);
  assign wr_pc = reg_wr && (reg_addr == IRQEB_PEND_C_ADDR);
  assign wr_pd = reg_wr && (reg_addr == IRQEB_PEND_D_ADDR);
  assign wr_pe = reg_wr && (reg_addr == IRQEB_PEND_E_ADDR);
  assign wr_ea = reg_wr && (reg_addr == IRQEB_ENAB_A_ADDR);
  assign wr_eb = reg_wr && (reg_addr == IRQEB_ENAB_B_ADDR);
  assign wr_ec = reg_wr && (reg_addr == IRQEB_ENAB_C_ADDR);
  assign wr_ed = reg_wr && (reg_addr == IRQEB_ENAB_D_ADDR);

  // request flags, one always_ff for the whole request side
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      // R15 banks a-d clear
      pend_a_r <= IRQEB_RST_ZERO;
      pend_b_r <= IRQEB_RST_ZERO;
      pend_c_r <= IRQEB_RST_ZERO;
      pend_d_r <= IRQEB_RST_ZERO;
      // R16 bank e loads e0
      pend_e_r <= IRQEB_RST_E;
    end
    else
    begin
      // R1 R2 R3 R4 source sets, unused bits masked (R10 R11 R12 R13)
      pend_a_r <= irqeb_flag_nxt(pend_a_r, wr_pa, reg_wdata, clr_a, set_a, IRQEB_MASK_A);
      pend_b_r <= irqeb_flag_nxt(pend_b_r, wr_pb, reg_wdata, clr_b, set_b, IRQEB_MASK_B);
      pend_c_r <= irqeb_flag_nxt(pend_c_r, wr_pc, reg_wdata, clr_c, set_c, IRQEB_MASK_C);
      pend_d_r <= irqeb_flag_nxt(pend_d_r, wr_pd, reg_wdata, clr_d, set_d, IRQEB_MASK_D);
      // R5 R14 upper bits stay one whatever is written
      pend_e_r <= irqeb_flag_nxt(pend_e_r, wr_pe, reg_wdata, clr_e, set_e, IRQEB_MASK_E)
                  | IRQEB_FIXED_E;
    end
  end

  // ----------------------------------------------------------------
  // enable banks
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      // R15 enables clear
      enab_a_r <= IRQEB_RST_ZERO;
      enab_b_r <= IRQEB_RST_ZERO;
      enab_c_r <= IRQEB_RST_ZERO;
      enab_d_r <= IRQEB_RST_ZERO;
    end
    else
    begin
      // R6 R7 R8 R9 masked enable writes
      if (wr_ea)
      begin
        enab_a_r <= reg_wdata & IRQEB_MASK_A;
      end
      if (wr_eb)
      begin
        enab_b_r <= reg_wdata & IRQEB_MASK_B;
      end
      if (wr_ec)
      begin
        enab_c_r <= reg_wdata & IRQEB_MASK_C;
      end
      if (wr_ed)
      begin
        enab_d_r <= reg_wdata & IRQEB_MASK_D;
      end
    end
  end

  // ----------------------------------------------------------------
  // read port: data one cycle after strobe, zero otherwise
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata_r <= 8'h00;
    end
    else if (reg_rd)
    begin
      unique case (reg_addr)
        IRQEB_PEND_A_ADDR: rdata_r <= pend_a_r;
        IRQEB_PEND_B_ADDR: rdata_r <= pend_b_r;
        IRQEB_PEND_C_ADDR: rdata_r <= pend_c_r;
        IRQEB_PEND_D_ADDR: rdata_r <= pend_d_r;
        IRQEB_PEND_E_ADDR: rdata_r <= pend_e_r;
        IRQEB_ENAB_A_ADDR: rdata_r <= enab_a_r;
        IRQEB_ENAB_B_ADDR: rdata_r <= enab_b_r;
        IRQEB_ENAB_C_ADDR: rdata_r <= enab_c_r;
        IRQEB_ENAB_D_ADDR: rdata_r <= enab_d_r;
        // unmapped reads as zero
        default: rdata_r <= 8'h00;
      endcase
    end
    else
    begin
      rdata_r <= 8'h00;
    end
  end

  assign reg_rdata = rdata_r;

  // ----------------------------------------------------------------
  // arbiter hookup; outputs are the arbiter's flops
  // ----------------------------------------------------------------
  // R18 flags feed the arbiter as pending requests
  assign fl.pending = irqeb_gather({pend_e_r, pend_d_r, pend_c_r, pend_b_r, pend_a_r});
  assign fl.enable = irqeb_gather({8'h00, enab_d_r, enab_c_r, enab_b_r, enab_a_r})
                     | {5'h1f, 24'h0};
  assign fl.ack = core_ack;

  irqeb_arbiter u_arb (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .fl(fl)
  );

  assign irq_src_id = fl.src_id;
  assign irq_valid = fl.src_valid;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_set_beats_clr: assert property (@(posedge sys_clk) disable iff (!nrst) // R23
    (wr_pb && !reg_wdata[0] && src_event[4]) |=> pend_b_r[0])
    else $error("hardware set lost against software clear");
  a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!nrst) // R10
    (pend_a_r[5:2] == 4'h0) && (enab_a_r[5:2] == 4'h0) && !pend_b_r[7] && !enab_b_r[7])
    else $error("reserved bits not zero");
  a_fixed_ones: assert property (@(posedge sys_clk) disable iff (!nrst) // R14
    pend_e_r[7:5] == 3'h7)
    else $error("fifth bank upper bits not one");
  a_ack_clears: assert property (@(posedge sys_clk) disable iff (!nrst) // R20
    (core_ack && irq_valid && irq_src_id == 5'd4 && !src_event[4] && !wr_pb) |=> !pend_b_r[0])
    else $error("accepted flag not cleared");
  a_read_timing: assert property (@(posedge sys_clk) disable iff (!nrst) // R19
    (reg_rd && reg_addr == IRQEB_PEND_D_ADDR) |=> reg_rdata == $past(pend_d_r))
    else $error("read answer wrong");
  a_write_flag: assert property (@(posedge sys_clk) disable iff (!nrst) // R17
    (wr_pd && !core_ack) |=> pend_d_r == (($past(reg_wdata) | $past(set_d)) & IRQEB_MASK_D))
    else $error("flag write not stored");
  a_event_sets: assert property (@(posedge sys_clk) disable iff (!nrst) // R1
    src_event[0] |=> pend_a_r[0])
    else $error("source event did not set flag");
  c_read: cover property (@(posedge sys_clk) disable iff (!nrst) reg_rd ##1 reg_rdata != 8'h00);
  c_clash: cover property (@(posedge sys_clk) disable iff (!nrst) wr_pb && src_event[4]);
  c_ack: cover property (@(posedge sys_clk) disable iff (!nrst) core_ack && irq_valid);
endmodule
`default_nettype wire

// >>> bench/irqeb_core_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// core sequencer stand-in: takes offers after a set delay
// ----------------------------------------------------------------
module irqeb_core_model
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic irq_valid,
  input wire logic [4:0] irq_src_id,
  input wire logic take_en,
  input wire logic [3:0] take_dly,
  output logic core_ack,
  output logic [4:0] taken_id,
  output logic [7:0] taken_cnt
);
  logic [3:0] wait_r; // cycles the offer has stood

  // ack is a one-cycle pulse; a gap follows so the bank can re-offer
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      core_ack <= 1'b0;
      taken_id <= 5'h1f;
      taken_cnt <= 8'h00;
      wait_r <= 4'h0;
    end
    else if (core_ack)
    begin
      // drop the pulse, restart the wait
      core_ack <= 1'b0;
      wait_r <= 4'h0;
    end
    else if (irq_valid && take_en)
    begin
      // slow mode: let the offer stand take_dly cycles first
      if (wait_r >= take_dly)
      begin
        core_ack <= 1'b1;
        taken_id <= irq_src_id;
        taken_cnt <= taken_cnt + 8'h01;
      end
      else
        wait_r <= wait_r + 4'h1;
    end
    else
      wait_r <= 4'h0; // offer withdrawn
  end
endmodule
`default_nettype wire

// >>> bench/interrupt_request_enable_bank_tb.sv
`timescale 1ns/10ps
`default_nettype none
module interrupt_request_enable_bank_tb;
  import irqeb_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic sys_clk, nrst, reg_wr, reg_rd, core_ack, irq_valid, take_en;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, taken_cnt;
  logic [28:0] src_event;
  logic [4:0] irq_src_id, taken_id;
  logic [3:0] take_dly;
  int error_cnt = 0; // mismatches
  int n_checks = 0; // comparisons
  int cyc = 0; // timeout counter
  typedef struct {logic [15:0] a; logic [7:0] d; logic [7:0] e;} irqeb_row_t;
  // address, write data, read-back; 0031/0033 literal on purpose
  irqeb_row_t rows [0:9] = '{
    '{IRQEB_PEND_A_ADDR, 8'hff, 8'hc3},
    '{16'h0031, 8'hff, 8'h7f},
    '{IRQEB_PEND_C_ADDR, 8'hff, 8'hcf},
    '{16'h0033, 8'hff, 8'hbf},
    '{IRQEB_PEND_E_ADDR, 8'h00, 8'he0},
    '{IRQEB_PEND_E_ADDR, 8'hff, 8'hff},
    '{IRQEB_ENAB_A_ADDR, 8'hc3, 8'hc3},
    '{IRQEB_ENAB_B_ADDR, 8'h7f, 8'h7f},
    '{IRQEB_ENAB_C_ADDR, 8'hcf, 8'hcf},
    '{IRQEB_ENAB_D_ADDR, 8'hbf, 8'hbf}};
  logic [4:0] ack_order [0:2] = '{5'd0, 5'd4, 5'd11}; // lowest index first

  irqeb_bank uut (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_event(src_event),
    .core_ack(core_ack), .irq_src_id(irq_src_id), .irq_valid(irq_valid));
  irqeb_core_model core (.sys_clk(sys_clk), .nrst(nrst), .irq_valid(irq_valid),
    .irq_src_id(irq_src_id), .take_en(take_en), .take_dly(take_dly), .core_ack(core_ack),
    .taken_id(taken_id), .taken_cnt(taken_cnt));

  // ----------------------------------------------------------------
  // clock and timeout
  // ----------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // ceiling far above the few hundred cycles the run needs
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string what);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
  endtask
  task automatic pulse(input int i);
    @(posedge sys_clk);
    src_event[i] <= 1'b1;
    @(posedge sys_clk);
    src_event[i] <= 1'b0;
  endtask
  // bounded wait on the core model's accept count
  task automatic wait_cnt(input logic [7:0] n);
    int k;
    k = 0;
    while (taken_cnt !== n && k < 200)
    begin
      @(posedge sys_clk);
      k++;
    end
    #1;
  endtask
  // source index to register and bit, in vector order
  function automatic logic [15:0] src_addr(input int i);
    if (i < 4) return IRQEB_PEND_A_ADDR;
    if (i < 11) return IRQEB_PEND_B_ADDR;
    if (i < 17) return IRQEB_PEND_C_ADDR;
    if (i < 24) return IRQEB_PEND_D_ADDR;
    return IRQEB_PEND_E_ADDR;
  endfunction
  function automatic logic [7:0] src_bit(input int i);
    int j;
    if (i < 4) j = (i < 2) ? i : i + 4;
    else if (i < 11) j = i - 4;
    else if (i < 17) j = (i < 15) ? i - 11 : i - 9;
    else if (i < 24) j = (i < 23) ? i - 17 : 7;
    else j = i - 24;
    return (8'h01 << j) | ((i > 23) ? IRQEB_FIXED_E : 8'h00);
  endfunction
  // every register at its reset value; row 4 repeats bank e
  task automatic reset_vals();
    for (int i = 0; i < 10; i++)
      if (i != 4)
        rd(rows[i].a, (rows[i].a == IRQEB_PEND_E_ADDR) ? IRQEB_RST_E : IRQEB_RST_ZERO, "rst");
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    nrst = 1'b0;
    {reg_wr, reg_rd, take_en} = 3'b000;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    src_event = '0;
    take_dly = 4'h0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    reset_vals();
    @(posedge sys_clk);
    #1;
    chk("rdata_idle", 8'h00, reg_rdata);
    $display("test reset done");
    // ordinary cases, reserved bits dropped or fixed
    for (int i = 0; i < 10; i++)
    begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e, "row");
    end
    for (int i = 0; i < 10; i++)
      wr(rows[i].a, 8'h00);
    $display("test table done");
    // each source sets its own flag; software clears it
    for (int i = 0; i < 29; i++)
    begin
      pulse(i);
      rd(src_addr(i), src_bit(i), "flag");
      wr(src_addr(i), 8'h00);
    end
    rd(IRQEB_PEND_E_ADDR, 8'he0, "clr_e");
    $display("test sources done");
    // three enabled requests, one disabled, slow acceptance
    wr(IRQEB_ENAB_A_ADDR, 8'h01);
    wr(IRQEB_ENAB_B_ADDR, 8'h01);
    wr(IRQEB_ENAB_C_ADDR, 8'h01);
    pulse(11);
    pulse(4);
    pulse(1);
    wr(IRQEB_PEND_A_ADDR, 8'h03); // keep disabled bit 1 pending
    repeat (3) @(posedge sys_clk);
    #1;
    chk("valid", 8'h01, {7'h0, irq_valid});
    chk("id", 8'h00, {3'h0, irq_src_id});
    take_dly <= 4'h3;
    take_en <= 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      wait_cnt(8'(k + 1));
      chk("ack_id", {3'h0, ack_order[k]}, {3'h0, taken_id});
    end
    repeat (4) @(posedge sys_clk);
    #1;
    chk("valid_off", 8'h00, {7'h0, irq_valid});
    take_en <= 1'b0;
    rd(IRQEB_PEND_A_ADDR, 8'h02, "ack_a");
    rd(IRQEB_PEND_B_ADDR, 8'h00, "ack_b");
    rd(IRQEB_PEND_C_ADDR, 8'h00, "ack_c");
    $display("test offer done");
    // set and software clear in the same cycle
    wr(IRQEB_PEND_B_ADDR, 8'h01);
    @(posedge sys_clk);
    reg_addr <= IRQEB_PEND_B_ADDR;
    reg_wdata <= 8'h00;
    reg_wr <= 1'b1;
    src_event[5] <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    src_event[5] <= 1'b0;
    rd(IRQEB_PEND_B_ADDR, 8'h02, "set_wins");
    $display("test collision done");
    // unmapped place reads zero, write leaves others alone
    rd(16'h0035, 8'h00, "unmapped");
    wr(16'h0035, 8'hff);
    rd(IRQEB_ENAB_A_ADDR, 8'h01, "after_unmapped");
    rd(IRQEB_PEND_E_ADDR, 8'he0, "e_fixed");
    $display("test unmapped done");
    // second reset in mid-run
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("rst_id", 8'h1f, {3'h0, irq_src_id});
    nrst <= 1'b1;
    reset_vals();
    $display("test second reset done");
    give_verdict();
  end
endmodule
`default_nettype wire
